/* bench/pcacc_checker.sv */
// port assertions for the capture/compare block
`timescale 1ns/1ns
module pcacc_checker (
    input wire logic                          clk_i,
    input wire logic                          rst_n_i,
    input wire logic [7:0]                    sfr_addr_i,
    input wire logic                          sfr_wr_i,
    input wire logic                          sfr_rd_i,
    input wire logic [7:0]                    sfr_wdata_i,
    input wire logic [7:0]                    sfr_rdata_o,
    input wire logic                          counter_tick_i,
    input wire logic                          counter_run_o,
    input wire logic                          global_irq_enable_i,
    input wire logic                          array_irq_enable_i,
    input wire logic                          irq_o,
    input wire logic [pcacc_pkg::NUM_MOD-1:0] module_io_line_i,
    input wire logic [pcacc_pkg::NUM_MOD-1:0] module_io_line_o,
    input wire logic [pcacc_pkg::NUM_MOD-1:0] module_io_line_oe_o,
    input wire logic [pcacc_pkg::NUM_MOD-1:0] pin_level_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // request is registered, so a dropped enable shows one edge later
    irq_glob_a: assert property (!global_irq_enable_i |=> !irq_o)
        else $error("irq raised with global enable low");
    irq_arr_a: assert property (!array_irq_enable_i |=> !irq_o)
        else $error("irq raised with array enable low");
    // flags only clear by software, so the request holds without writes
    irq_hold_a: assert property (irq_o && global_irq_enable_i && array_irq_enable_i
        && !$past(sfr_wr_i) && !sfr_wr_i |=> irq_o) else $error("irq dropped without a write");
    // control register layout
    ctrl_rsvd_a: assert property (sfr_rd_i && sfr_addr_i == pcacc_pkg::ADDR_ARRAY_CTRL
        |=> sfr_rdata_o[5:3] == 3'h0) else $error("reserved control bits not zero");
    run_bit_a: assert property (sfr_wr_i && sfr_addr_i == pcacc_pkg::ADDR_ARRAY_CTRL
        |=> counter_run_o == $past(sfr_wdata_i[6])) else $error("run bit not taken");
    // a pin held long enough must be visible as the readable level
    pin_follow_a: assert property ($stable(module_io_line_i)[*7]
        |-> pin_level_o == module_io_line_i) else $error("pin level not followed");
    // outputs move only after a counter step or a register write
    out_tick_a: assert property ($changed(module_io_line_o)
        |-> $past(counter_tick_i) || $past(sfr_wr_i, 2)) else $error("output moved without cause");
    oe_wr_a: assert property ($changed(module_io_line_oe_o) |-> $past(sfr_wr_i, 2))
        else $error("output enable moved without a write");
endmodule

/* bench/pcacc_far_model.sv */
// shared counter and external pin driver facing the capture/compare block
`timescale 1ns/1ns
module pcacc_far_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        run_i,
    input  wire logic        load_i,
    input  wire logic [15:0] load_val_i,
    input  wire logic [2:0]  pin_req_i,
    output logic      [15:0] counter_o,
    output logic             tick_o,
    output logic             low_ovf_o,
    output logic             full_ovf_o,
    output logic      [2:0]  pin_o
);
    logic [1:0] held;
    // counter steps every clock while run is set; a load gives no tick
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {counter_o, tick_o, low_ovf_o, full_ovf_o} <= '0;
        end else if (load_i) begin
            {counter_o, tick_o, low_ovf_o, full_ovf_o} <= {load_val_i, 3'h0};
        end else begin
            tick_o     <= run_i;
            low_ovf_o  <= run_i && counter_o[7:0] == 8'hff;
            full_ovf_o <= run_i && counter_o == 16'hffff;
            counter_o  <= counter_o + {15'h0000, run_i};
        end
    end
    // pin changes are spaced so every level stands at least three clocks
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {pin_o, held} <= '0;
        end else if (held != 2'h0) begin
            held <= held - 2'h1;
        end else if (pin_req_i != pin_o) begin
            pin_o <= pin_req_i;
            held  <= 2'h2;
        end
    end
endmodule

/* bench/pcacc_top_tb.sv */
// self-checking bench for the capture/compare block
`timescale 1ns/1ns
module pcacc_top_tb;
    logic        clk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic [7:0]  sfr_addr_i = 8'h00;
    logic        sfr_wr_i = 1'b0;
    logic        sfr_rd_i = 1'b0;
    logic [7:0]  sfr_wdata_i = 8'h00;
    logic        glob_en = 1'b0;
    logic        arr_en = 1'b0;
    logic        load = 1'b0;
    logic [15:0] load_val = 16'h0000;
    logic [2:0]  pin_req = 3'h0;
    logic        rd_d = 1'b0;
    logic [7:0]  sfr_rdata_o;
    logic [15:0] cnt;
    logic        tick, low_ovf, full_ovf, run, irq_o;
    logic [2:0]  pin_ext, io_in, io_out, io_oe, pin_level_o;
    logic [7:0]  exp_q[$];
    int          mismatches = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          seed = 78674;
    int          hi, tg;

    always #5 clk_i = ~clk_i;
    // wire level: the block wins where it drives, else the outside driver
    assign io_in = (io_oe & io_out) | (~io_oe & pin_ext);

    pcacc_top u_pcacc_top (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
        .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
        .counter_i(cnt), .counter_tick_i(tick), .counter_low_ovf_i(low_ovf),
        .counter_full_ovf_i(full_ovf), .counter_run_o(run), .global_irq_enable_i(glob_en),
        .array_irq_enable_i(arr_en), .irq_o(irq_o), .module_io_line_i(io_in),
        .module_io_line_o(io_out), .module_io_line_oe_o(io_oe), .pin_level_o(pin_level_o));
    pcacc_far_model u_pcacc_far_model (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .run_i(run), .load_i(load), .load_val_i(load_val),
        .pin_req_i(pin_req), .counter_o(cnt), .tick_o(tick), .low_ovf_o(low_ovf),
        .full_ovf_o(full_ovf), .pin_o(pin_ext));

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        sfr_addr_i  <= a;
        sfr_wdata_i <= d;
        sfr_wr_i    <= 1'b1;
        @(posedge clk_i);
        sfr_wr_i    <= 1'b0;
    endtask
    // a read notes its expected data; the monitor below compares it
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_i);
        sfr_addr_i <= a;
        sfr_rd_i   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_i);
        sfr_rd_i   <= 1'b0;
    endtask
    task automatic ld(input logic [15:0] v);
        @(posedge clk_i);
        load_val <= v;
        load     <= 1'b1;
        @(posedge clk_i);
        load     <= 1'b0;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // counts high cycles and level changes of one output over n clocks
    task automatic meas(input int m, input int n, output int h, output int t);
        logic p;
        h = 0;
        t = 0;
        p = io_out[m];
        repeat (n) begin
            @(posedge clk_i);
            h += int'(io_out[m]);
            t += int'(io_out[m] !== p);
            p = io_out[m];
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // read data lands one edge after the strobe is taken
    always @(posedge clk_i) begin
        if (rd_d) begin
            chk("sfr_rdata", sfr_rdata_o, exp_q.pop_front());
        end
        rd_d <= sfr_rd_i;
    end
    // cut a hang short
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end

    initial begin
        logic [7:0] pw8 [3] = '{8'h00, 8'hc0, 8'hff};
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(8'hda, 8'h00);
        rd(8'hdc, 8'h00);
        rd(8'hd8, 8'h00);
        rd(8'h00, 8'h00);
        $display("test reset done");
        // low byte write clears compare enable, high byte write sets it
        wr(8'hda, 8'h49);
        wr(8'he9, 8'h40);
        rd(8'hda, 8'h09);
        wr(8'hf9, 8'h00);
        rd(8'hda, 8'h49);
        wr(8'hd8, 8'h40);
        cyc(80);
        rd(8'hd8, 8'h41);
        cyc(20);
        rd(8'hd8, 8'h41);
        repeat (4) begin
            {glob_en, arr_en} <= 2'($random(seed));
            cyc(3);
            chk("irq", irq_o, glob_en & arr_en);
        end
        wr(8'hd8, 8'h00);
        rd(8'hd8, 8'h00);
        $display("test timer done");
        // counter stopped so the captured word is exact
        ld(16'h1234);
        for (int i = 1; i < 4; i++) begin
            wr(8'hdb, {2'b00, 2'(i), 4'h0});
            pin_req[1] <= 1'b1;
            cyc(10);
            chk("pin_level", pin_level_o[1], 1'b1);
            rd(8'hd8, {6'h00, 1'(i >> 1), 1'b0});
            wr(8'hd8, 8'h00);
            pin_req[1] <= 1'b0;
            cyc(10);
            rd(8'hd8, {6'h00, 1'(i), 1'b0});
            wr(8'hd8, 8'h00);
        end
        rd(8'hea, 8'h34);
        rd(8'hfa, 8'h12);
        $display("test capture done");
        wr(8'hdc, 8'h4c);
        wr(8'heb, 8'h20);
        wr(8'hfb, 8'h00);
        ld(16'h0000);
        wr(8'hd8, 8'h40);
        cyc(60);
        chk("hso_out", {io_oe[2], io_out[2]}, 2'b11);
        rd(8'hd8, 8'h44);
        wr(8'hd8, 8'h40);
        wr(8'hda, 8'h42);
        foreach (pw8[i]) begin
            wr(8'he9, pw8[i]);
            wr(8'hf9, pw8[i]);
            cyc(300);
            meas(0, 256, hi, tg);
            chk("pwm8_high", hi, 256 - pw8[i]);
        end
        wr(8'he9, 8'h00);
        cyc(4);
        meas(0, 256, hi, tg);
        chk("pwm8_off", hi, 0);
        $display("test pwm8 done");
        // match bit set: frequency decode and toggling ignore it
        wr(8'hda, 8'h4e);
        for (int h = 0; h < 2; h++) begin
            wr(8'he9, 8'h00);
            wr(8'hf9, h ? 8'h00 : 8'h10);
            cyc(600);
            meas(0, 512, hi, tg);
            chk("freq_toggles", tg, h ? 2 : 32);
        end
        wr(8'hdb, 8'hcb);
        wr(8'hea, 8'hf0);
        wr(8'hfa, 8'hff);
        ld(16'hfff8);
        cyc(20);
        ld(16'hffd0);
        meas(1, 64, hi, tg);
        chk("pwm16_high", hi, 16);
        wr(8'hdc, 8'h0c);
        cyc(4);
        chk("odd_mode_out", {io_oe[2], io_out[2]}, 2'b00);
        $display("test outputs done");
        test_done();
    end
endmodule

bind pcacc_top pcacc_checker u_pcacc_checker (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
    .counter_tick_i(counter_tick_i), .counter_run_o(counter_run_o),
    .global_irq_enable_i(global_irq_enable_i), .array_irq_enable_i(array_irq_enable_i),
    .irq_o(irq_o), .module_io_line_i(module_io_line_i), .module_io_line_o(module_io_line_o),
    .module_io_line_oe_o(module_io_line_oe_o), .pin_level_o(pin_level_o));

/* hw/pcacc_pin_filter.sv */
// three-stage synchroniser and level filter for one module I/O line
`timescale 1ns/1ns
module pcacc_pin_filter (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic pin_i,
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);

    logic sync1;
    logic sync2;
    logic sync3;

    // sync1 feeds sync2 only; sync2 and sync3 agreeing rejects single-cycle glitches
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end else begin
            sync1 <= pin_i;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // accepted level moves only once two stages agree, so a level held 2 clocks is seen
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            level_o <= 1'b0;
            rise_o  <= 1'b0;
            fall_o  <= 1'b0;
        end else begin
            rise_o <= (sync2 == sync3) && sync3 && !level_o;
            fall_o <= (sync2 == sync3) && !sync3 && level_o;
            if (sync2 == sync3) begin
                level_o <= sync3;
            end
        end
    end

endmodule

/* hw/pcacc_pkg.sv */
// constants, register map and mode types for the counter array capture/compare block
// Contract
// - Three independent capture/compare modules share one 16-bit counter, each with one I/O line.
// - Capture mode copies the counter into the module register and sets its flag.
// - Capture edge selects pick rising, falling or either edge as trigger.
// - With both edge selects set, the pin level stays readable by software.
// - Module flags stay set until software writes them clear.
// - Flag interrupt enable raises a request only with global and array enables.
// - Software timer mode sets the flag when counter equals the module register.
// - Low compare byte write clears compare enable; high byte write sets it.
// - High-speed output mode inverts the I/O line on every 16-bit match.
// - Frequency mode: compare enable, toggle, width-mod set, wide select clear.
// - Frequency mode toggles on low byte match and adds high byte to low.
// - Frequency mode treats a high byte of zero as 256 timebase clocks.
// - 8-bit modulation: compare enable, width-mod set; toggle, wide select clear.
// - 8-bit modulation: high on low byte match, low on low byte overflow.
// - 8-bit modulation reloads the low byte from the high byte on wrap.
// - 8-bit duty is (256 - high byte)/256; zero gives constant high.
// - Clearing compare enable in modulation modes holds the output low.
// - 16-bit modulation: compare enable, width-mod and wide select set, toggle clear.
// - 16-bit modulation: high on full match, low on counter overflow.
// - 16-bit duty is (65536 - value)/65536; 0xffff gives one count high.
// - Module flags sit at bits 2, 1, 0 of array control beside the overflow flag.
package pcacc_pkg;

    localparam int NUM_MOD = 3;

    // special function register addresses
    localparam logic [7:0] ADDR_ARRAY_CTRL = 8'hd8;
    localparam logic [7:0] ADDR_MODE_BASE  = 8'hda;
    localparam logic [7:0] ADDR_CPL_BASE   = 8'he9;
    localparam logic [7:0] ADDR_CPH_BASE   = 8'hf9;

    // module_mode_control field positions
    localparam int BIT_WIDE_MOD   = 7;
    localparam int BIT_CMP_EN     = 6;
    localparam int BIT_CAP_RISE   = 5;
    localparam int BIT_CAP_FALL   = 4;
    localparam int BIT_MATCH_EN   = 3;
    localparam int BIT_TOGGLE_EN  = 2;
    localparam int BIT_WIDTH_MOD  = 1;
    localparam int BIT_FLAG_IRQEN = 0;

    // array_control_reg field positions
    localparam int BIT_OVF_FLAG   = 7;
    localparam int BIT_RUN        = 6;

    // reset values
    localparam logic [7:0]  RST_MODE    = 8'h00;
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [7:0]  RST_CTRL    = 8'h00;
    localparam logic [7:0]  READ_UNMAP  = 8'h00;

    typedef enum logic [2:0] {
        MODE_IDLE,
        MODE_CAPTURE,
        MODE_TIMER,
        MODE_HS_OUT,
        MODE_FREQ_OUT,
        MODE_PWM8,
        MODE_PWM16
    } pcacc_mode_e;

endpackage

/* hw/pcacc_top.sv */
// capture/compare modules of the counter array with their register interface
`timescale 1ns/1ns
module pcacc_top (
    input  wire logic                          clk_i,
    input  wire logic                          rst_n_i,
    // register access from the CPU core
    input  wire logic [7:0]                    sfr_addr_i,
    input  wire logic                          sfr_wr_i,
    input  wire logic                          sfr_rd_i,
    input  wire logic [7:0]                    sfr_wdata_i,
    output logic      [7:0]                    sfr_rdata_o,
    // shared counter
    input  wire logic [15:0]                   counter_i,
    input  wire logic                          counter_tick_i,
    input  wire logic                          counter_low_ovf_i,
    input  wire logic                          counter_full_ovf_i,
    output logic                               counter_run_o,
    // interrupt enables and request
    input  wire logic                          global_irq_enable_i,
    input  wire logic                          array_irq_enable_i,
    output logic                               irq_o,
    // module I/O lines
    input  wire logic [pcacc_pkg::NUM_MOD-1:0] module_io_line_i,
    output logic      [pcacc_pkg::NUM_MOD-1:0] module_io_line_o,
    output logic      [pcacc_pkg::NUM_MOD-1:0] module_io_line_oe_o,
    output logic      [pcacc_pkg::NUM_MOD-1:0] pin_level_o
);

    localparam int N = pcacc_pkg::NUM_MOD;

    // per-module state, one entry per module
    logic [7:0]              mode_ctrl [N];
    logic [7:0]              cmp_low   [N];
    logic [7:0]              cmp_high  [N];
    logic [N-1:0]            module_event_flag;
    logic [N-1:0]            out_level;
    logic [N-1:0]            pin_rise;
    logic [N-1:0]            pin_fall;
    pcacc_pkg::pcacc_mode_e  mode      [N];
    logic [N-1:0]            capture_hit;
    logic [N-1:0]            match_hit;

    // array-wide state
    logic                    ovf_flag;
    logic                    run_ctrl;
    logic                    wr_ctrl;
    logic [7:0]              next_rdata;

    assign wr_ctrl = sfr_wr_i && (sfr_addr_i == pcacc_pkg::ADDR_ARRAY_CTRL);

    // decode the mode select bits; anything outside the six modes is idle
    function automatic pcacc_pkg::pcacc_mode_e decode_mode(input logic [7:0] m);
        logic cmp;
        logic rise;
        logic fall;
        logic mat;
        logic tog;
        logic pwm;
        logic wide;
        cmp  = m[pcacc_pkg::BIT_CMP_EN];
        rise = m[pcacc_pkg::BIT_CAP_RISE];
        fall = m[pcacc_pkg::BIT_CAP_FALL];
        mat  = m[pcacc_pkg::BIT_MATCH_EN];
        tog  = m[pcacc_pkg::BIT_TOGGLE_EN];
        pwm  = m[pcacc_pkg::BIT_WIDTH_MOD];
        wide = m[pcacc_pkg::BIT_WIDE_MOD];
        decode_mode = pcacc_pkg::MODE_IDLE;
        if ((rise || fall) && !mat && !tog && !pwm) begin
            decode_mode = pcacc_pkg::MODE_CAPTURE;
        end else if (!rise && !fall && cmp) begin
            if (mat && !tog && !pwm) begin
                decode_mode = pcacc_pkg::MODE_TIMER;
            end else if (mat && tog && !pwm) begin
                decode_mode = pcacc_pkg::MODE_HS_OUT;
            end else if (tog && pwm && !wide) begin
                decode_mode = pcacc_pkg::MODE_FREQ_OUT;
            end else if (!tog && pwm && !wide) begin
                decode_mode = pcacc_pkg::MODE_PWM8;
            end else if (!tog && pwm && wide) begin
                decode_mode = pcacc_pkg::MODE_PWM16;
            end
        end
    endfunction

    // one slice per module; the three slices share only the counter
    for (genvar i = 0; i < N; i++) begin : g_mod
        logic [7:0]  my_addr_mode;
        logic [7:0]  my_addr_low;
        logic [7:0]  my_addr_high;
        logic        wr_mode;
        logic        wr_low;
        logic        wr_high;
        logic        full_match;
        logic        low_match;
        logic        edge_ok;
        logic        pwm_gate;
        logic [7:0]  low_cmp_val;

        assign my_addr_mode = pcacc_pkg::ADDR_MODE_BASE + 8'(i);
        assign my_addr_low  = pcacc_pkg::ADDR_CPL_BASE + 8'(i);
        assign my_addr_high = pcacc_pkg::ADDR_CPH_BASE + 8'(i);
        assign wr_mode      = sfr_wr_i && (sfr_addr_i == my_addr_mode);
        assign wr_low       = sfr_wr_i && (sfr_addr_i == my_addr_low);
        assign wr_high      = sfr_wr_i && (sfr_addr_i == my_addr_high);
        assign mode[i]      = decode_mode(mode_ctrl[i]);

        pcacc_pin_filter u_filter (
            .clk_i   (clk_i),
            .rst_n_i (rst_n_i),
            .pin_i   (module_io_line_i[i]),
            .level_o (pin_level_o[i]),
            .rise_o  (pin_rise[i]),
            .fall_o  (pin_fall[i])
        );

        // edge qualification by the rise and fall selects
        assign edge_ok = (pin_rise[i] && mode_ctrl[i][pcacc_pkg::BIT_CAP_RISE])
                      || (pin_fall[i] && mode_ctrl[i][pcacc_pkg::BIT_CAP_FALL]);
        assign capture_hit[i] = (mode[i] == pcacc_pkg::MODE_CAPTURE) && edge_ok;

        // pwm8 wrap tick compares the reload value so a zero high byte never drops
        assign low_cmp_val = (counter_low_ovf_i && (mode[i] == pcacc_pkg::MODE_PWM8))
                           ? cmp_high[i] : cmp_low[i];
        assign full_match  = counter_tick_i && (counter_i == {cmp_high[i], cmp_low[i]});
        assign low_match   = counter_tick_i && (counter_i[7:0] == low_cmp_val);
        assign match_hit[i] = full_match && mode_ctrl[i][pcacc_pkg::BIT_MATCH_EN]
                            && mode_ctrl[i][pcacc_pkg::BIT_CMP_EN]
                            && (mode[i] != pcacc_pkg::MODE_IDLE)
                            && (mode[i] != pcacc_pkg::MODE_CAPTURE);
        assign pwm_gate = mode_ctrl[i][pcacc_pkg::BIT_CMP_EN]
                       && mode_ctrl[i][pcacc_pkg::BIT_WIDTH_MOD]
                       && !mode_ctrl[i][pcacc_pkg::BIT_TOGGLE_EN];

        // mode register: plain write, but the low/high byte writes steer compare enable
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                mode_ctrl[i] <= pcacc_pkg::RST_MODE;
            end else if (wr_mode) begin
                mode_ctrl[i] <= sfr_wdata_i;
            end else if (wr_low) begin
                mode_ctrl[i][pcacc_pkg::BIT_CMP_EN] <= 1'b0;
            end else if (wr_high) begin
                mode_ctrl[i][pcacc_pkg::BIT_CMP_EN] <= 1'b1;
            end
        end

        // low byte: capture beats a software write so a captured time is never torn
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                cmp_low[i] <= pcacc_pkg::RST_BYTE;
            end else if (capture_hit[i]) begin
                cmp_low[i] <= counter_i[7:0];
            end else if (wr_low) begin
                cmp_low[i] <= sfr_wdata_i;
            end else if (mode[i] == pcacc_pkg::MODE_FREQ_OUT && low_match) begin
                cmp_low[i] <= cmp_low[i] + cmp_high[i];
            end else if (mode[i] == pcacc_pkg::MODE_PWM8 && counter_low_ovf_i) begin
                cmp_low[i] <= cmp_high[i];
            end
        end

        // high byte
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                cmp_high[i] <= pcacc_pkg::RST_BYTE;
            end else if (capture_hit[i]) begin
                cmp_high[i] <= counter_i[15:8];
            end else if (wr_high) begin
                cmp_high[i] <= sfr_wdata_i;
            end
        end

        // event flag: hardware set wins over a software clear in the same cycle
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                module_event_flag[i] <= 1'b0;
            end else if (capture_hit[i] || match_hit[i]) begin
                module_event_flag[i] <= 1'b1;
            end else if (wr_ctrl) begin
                module_event_flag[i] <= sfr_wdata_i[i];
            end
        end

        // output line level per mode
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                out_level[i] <= 1'b0;
            end else begin
                unique case (mode[i])
                    pcacc_pkg::MODE_HS_OUT: begin
                        if (full_match) begin
                            out_level[i] <= !out_level[i];
                        end
                    end
                    pcacc_pkg::MODE_FREQ_OUT: begin
                        if (low_match) begin
                            out_level[i] <= !out_level[i];
                        end
                    end
                    pcacc_pkg::MODE_PWM8: begin
                        // match checked first so a zero high byte stays high
                        if (low_match) begin
                            out_level[i] <= 1'b1;
                        end else if (counter_low_ovf_i) begin
                            out_level[i] <= 1'b0;
                        end
                    end
                    pcacc_pkg::MODE_PWM16: begin
                        if (full_match) begin
                            out_level[i] <= 1'b1;
                        end else if (counter_full_ovf_i) begin
                            out_level[i] <= 1'b0;
                        end
                    end
                    pcacc_pkg::MODE_IDLE,
                    pcacc_pkg::MODE_CAPTURE,
                    pcacc_pkg::MODE_TIMER: begin
                        // modulation with compare enable clear decodes idle: output low
                        out_level[i] <= 1'b0;
                    end
                endcase
            end
        end

        // drive the line in output modes, and hold it driven low for zero duty
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                module_io_line_oe_o[i] <= 1'b0;
            end else begin
                module_io_line_oe_o[i] <= (mode[i] == pcacc_pkg::MODE_HS_OUT)
                                       || (mode[i] == pcacc_pkg::MODE_FREQ_OUT)
                                       || (mode[i] == pcacc_pkg::MODE_PWM8)
                                       || (mode[i] == pcacc_pkg::MODE_PWM16)
                                       || (!mode_ctrl[i][pcacc_pkg::BIT_CMP_EN]
                                           && mode_ctrl[i][pcacc_pkg::BIT_WIDTH_MOD]
                                           && !pwm_gate);
            end
        end
    end

    assign module_io_line_o = out_level;

    // counter overflow flag beside the module flags, same set-over-clear policy
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ovf_flag <= 1'b0;
        end else if (counter_full_ovf_i) begin
            ovf_flag <= 1'b1;
        end else if (wr_ctrl) begin
            ovf_flag <= sfr_wdata_i[pcacc_pkg::BIT_OVF_FLAG];
        end
    end

    // run control for the external counter
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_ctrl <= 1'b0;
        end else if (wr_ctrl) begin
            run_ctrl <= sfr_wdata_i[pcacc_pkg::BIT_RUN];
        end
    end

    assign counter_run_o = run_ctrl;

    // interrupt request: any enabled flag, gated by both upper-level enables;
    // registered, so it rises one cycle after the flag
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= 1'b0;
            for (int k = 0; k < N; k++) begin
                if (module_event_flag[k] && mode_ctrl[k][pcacc_pkg::BIT_FLAG_IRQEN]
                    && global_irq_enable_i && array_irq_enable_i) begin
                    irq_o <= 1'b1;
                end
            end
        end
    end

    // read multiplexer; unmapped addresses return zero, reserved bits read zero
    always_comb begin
        next_rdata = pcacc_pkg::READ_UNMAP;
        if (sfr_addr_i == pcacc_pkg::ADDR_ARRAY_CTRL) begin
            next_rdata = pcacc_pkg::RST_CTRL;
            next_rdata[pcacc_pkg::BIT_OVF_FLAG] = ovf_flag;
            next_rdata[pcacc_pkg::BIT_RUN]      = run_ctrl;
            next_rdata[N-1:0]                   = module_event_flag;
        end
        for (int k = 0; k < N; k++) begin
            if (sfr_addr_i == pcacc_pkg::ADDR_MODE_BASE + 8'(k)) begin
                next_rdata = mode_ctrl[k];
            end
            if (sfr_addr_i == pcacc_pkg::ADDR_CPL_BASE + 8'(k)) begin
                next_rdata = cmp_low[k];
            end
            if (sfr_addr_i == pcacc_pkg::ADDR_CPH_BASE + 8'(k)) begin
                next_rdata = cmp_high[k];
            end
        end
    end

    // read data is registered and holds until the next read
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sfr_rdata_o <= pcacc_pkg::READ_UNMAP;
        end else if (sfr_rd_i) begin
            sfr_rdata_o <= next_rdata;
        end
    end

endmodule
